// >>> logic/lcdhcp_params.svh
`ifndef LCDHCP_PARAMS_SVH
`define LCDHCP_PARAMS_SVH

// -----------------------------------------------------------------
// Command codes.
// -----------------------------------------------------------------
`define LCDHCP_CMD_CURSOR  8'h21
`define LCDHCP_CMD_OFFSET  8'h22
`define LCDHCP_CMD_POINTER 8'h24

// -----------------------------------------------------------------
// Status bit positions.
// -----------------------------------------------------------------
`define LCDHCP_ST_CMD   0
`define LCDHCP_ST_RW    1
`define LCDHCP_ST_ARD   2
`define LCDHCP_ST_AWR   3
`define LCDHCP_ST_CTRL  5
`define LCDHCP_ST_ERR   6
`define LCDHCP_ST_BLINK 7

// -----------------------------------------------------------------
// Reset values and timing.
// -----------------------------------------------------------------
`define LCDHCP_RST_BYTE 8'h00
`define LCDHCP_RST_PTR  16'h0000
`define LCDHCP_CLK_NS   10
`define LCDHCP_EXEC_NS  40
`define LCDHCP_EXEC_CYC \
    ((`LCDHCP_EXEC_NS + `LCDHCP_CLK_NS - 1) / `LCDHCP_CLK_NS)

`endif

// >>> logic/lcdhcp_pkg.sv
`default_nettype none
package lcdhcp_pkg;

    // -------------------------------------------------------------
    // Types.
    // -------------------------------------------------------------
    // Command sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_EXEC
    } lcdhcp_state_e;

    // Cursor position as loaded by its command.
    typedef struct packed {
        logic [4:0] row;
        logic [6:0] column;
    } lcdhcp_cursor_s;

    // Two most recent parameter bytes.
    typedef struct packed {
        logic [7:0] older;
        logic [7:0] newest;
    } lcdhcp_param_s;

endpackage : lcdhcp_pkg
`default_nettype wire

// >>> logic/lcdhcp_port.sv
`include "lcdhcp_params.svh"
`default_nettype none
module lcdhcp_port (
    // Clock and reset.
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    // Host parallel bus, strobes active low.
    input  wire logic                  CE_N,
    input  wire logic                  RD_N,
    input  wire logic                  WR_N,
    input  wire logic                  CD,
    input  wire logic [7:0]            DATA_IN,
    output var  logic [7:0]            DATA_OUT,
    output var  logic                  DATA_OE,
    // Controller condition inputs.
    input  wire logic                  LINE_END,
    input  wire logic                  AUTO_RD,
    input  wire logic                  AUTO_WR,
    input  wire logic                  CTRL_EN,
    input  wire logic                  BLINK_ON,
    input  wire logic                  PEEK_FAIL,
    input  wire logic                  PEEK_START,
    // Character generator address inputs.
    input  wire logic [7:0]            CHAR_CODE,
    input  wire logic [2:0]            LINE_CNT,
    // Loaded registers and command report.
    output var  lcdhcp_pkg::lcdhcp_cursor_s CURSOR,
    output var  logic [4:0]            CG_OFFSET,
    output var  logic [15:0]           ADDR_PTR,
    output var  logic                  PTR_LOAD,
    output var  logic [15:0]           CG_ADDR,
    output var  logic                  CMD_OTHER,
    output var  logic [7:0]            CMD_CODE
);
    import lcdhcp_pkg::*;

    // -------------------------------------------------------------
    // Host strobe decode.
    // -------------------------------------------------------------
    wire logic rd_stat;               // Select high, read low, write high.
    wire logic wr_act;                // Write strobe under chip enable.
    wire logic wr_start;              // First cycle of a write strobe.
    wire logic cmd_wr;                // Command byte event.
    wire logic prm_wr;                // Parameter byte event.
    logic      wr_q;                  // Write strobe one cycle ago.

    assign rd_stat  = ~CE_N & ~RD_N & WR_N & CD;
    assign wr_act   = ~CE_N & ~WR_N & RD_N;
    assign wr_start = wr_act & ~wr_q;
    assign cmd_wr   = wr_start & CD;
    assign prm_wr   = wr_start & ~CD;

    // Edge memory for the write strobe.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= wr_act;
        end
    end

    // -------------------------------------------------------------
    // Command sequencer.
    // -------------------------------------------------------------
    lcdhcp_state_e st_q;              // Current state.
    lcdhcp_state_e st_d;              // Next state.
    logic [3:0]    cnt_q;             // Execution cycles left.
    logic [3:0]    cnt_d;             // Next count.
    logic [7:0]    cmd_q;             // Command being run.
    wire logic     idle;              // Ready for a new command.
    wire logic     hold_cmd;          // New command must wait.
    wire logic     apply;             // Last execution cycle.
    wire logic     prm_take;          // Parameter byte accepted.
    wire logic     cmd_take;          // Command byte accepted.

    localparam logic [3:0] EXEC_CYC = 4'(`LCDHCP_EXEC_CYC);

    assign idle     = (st_q == ST_IDLE);
    assign hold_cmd = LINE_END & ~DATA_IN[7];
    assign apply    = (st_q == ST_EXEC) & (cnt_q == 4'h1);
    assign prm_take = prm_wr & (st_q != ST_EXEC);
    // Commands that arrive while one is pending are dropped.
    assign cmd_take = cmd_wr & idle;

    // Next-state logic for the sequencer.
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            // An accepted command either waits or starts.
            ST_IDLE: begin
                if (cmd_take && hold_cmd) begin
                    st_d = ST_HOLD;
                end else if (cmd_take) begin
                    st_d  = ST_EXEC;
                    cnt_d = EXEC_CYC;
                end
            end
            // The held command starts once LINE_END goes low.
            ST_HOLD: begin
                if (!LINE_END) begin
                    st_d  = ST_EXEC;
                    cnt_d = EXEC_CYC;
                end
            end
            // Count down the execution time.
            ST_EXEC: begin
                cnt_d = cnt_q - 4'h1;
                if (apply) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    // State, count and latched command code.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            st_q  <= ST_IDLE;
            cnt_q <= 4'h0;
            cmd_q <= `LCDHCP_RST_BYTE;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            if (cmd_take) begin
                cmd_q <= DATA_IN;
            end
        end
    end

    // -------------------------------------------------------------
    // Parameter bytes.
    // -------------------------------------------------------------
    // Keeping only two bytes means extra ones simply fall out.
    lcdhcp_param_s prm_q;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            prm_q <= '0;
        end else if (prm_take) begin
            prm_q <= {prm_q.newest, DATA_IN};
        end
    end

    // -------------------------------------------------------------
    // Register-set commands.
    // -------------------------------------------------------------
    wire logic is_cur;                // Cursor command runs.
    wire logic is_off;                // Offset command runs.
    wire logic is_ptr;                // Pointer command runs.

    assign is_cur = apply & (cmd_q == `LCDHCP_CMD_CURSOR);
    assign is_off = apply & (cmd_q == `LCDHCP_CMD_OFFSET);
    assign is_ptr = apply & (cmd_q == `LCDHCP_CMD_POINTER);

    // Cursor is touched by nothing but its own command.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CURSOR <= '0;
        end else if (is_cur) begin
            CURSOR.column <= prm_q.older[6:0];
            CURSOR.row    <= prm_q.newest[4:0];
        end
    end
    // The second byte of the offset command is not checked.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CG_OFFSET <= 5'h00;
        end else if (is_off) begin
            CG_OFFSET <= prm_q.older[4:0];
        end
    end
    // Pointer and its load pulse for the memory sequencer.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ADDR_PTR <= `LCDHCP_RST_PTR;
            PTR_LOAD <= 1'b0;
        end else begin
            PTR_LOAD <= is_ptr;
            if (is_ptr) begin
                ADDR_PTR <= {prm_q.newest, prm_q.older};
            end
        end
    end
    // Other codes are handed on with a one-cycle pulse.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CMD_OTHER <= 1'b0;
            CMD_CODE  <= `LCDHCP_RST_BYTE;
        end else begin
            CMD_OTHER <= apply & ~is_cur & ~is_off & ~is_ptr;
            if (apply) begin
                CMD_CODE <= cmd_q;
            end
        end
    end
    // Generator address, registered for timing.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CG_ADDR <= `LCDHCP_RST_PTR;
        end else begin
            CG_ADDR <= {CG_OFFSET, CHAR_CODE, LINE_CNT};
        end
    end

    // -------------------------------------------------------------
    // Status word.
    // -------------------------------------------------------------
    logic       err_q;                // Sticky peek or copy error.
    wire logic  auto_on;              // Either auto mode active.
    wire logic  ready;                // No command pending.
    logic [7:0] status;               // Assembled status word.

    assign auto_on = AUTO_RD | AUTO_WR;
    assign ready   = idle;
    // A failure in the cycle of a new start still sets the flag.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            err_q <= 1'b0;
        end else if (PEEK_FAIL) begin
            err_q <= 1'b1;
        end else if (PEEK_START) begin
            err_q <= 1'b0;
        end
    end

    // Bits 0 and 1 read low in auto mode since they are invalid.
    always_comb begin
        status = 8'h00;
        status[`LCDHCP_ST_CMD]   = ready & ~auto_on;
        status[`LCDHCP_ST_RW]    = ready & ~auto_on;
        status[`LCDHCP_ST_ARD]   = ready & AUTO_RD;
        status[`LCDHCP_ST_AWR]   = ready & AUTO_WR;
        status[`LCDHCP_ST_CTRL]  = CTRL_EN;
        status[`LCDHCP_ST_ERR]   = err_q;
        status[`LCDHCP_ST_BLINK] = BLINK_ON;
    end
    // Data bus driver; the word trails the state by one cycle.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OUT <= status;
            DATA_OE  <= rd_stat;
        end
    end

    // -------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // The word loaded at the release edge is still the reset value, so
    // the status checks start one edge after reset has gone low.
    property p_stat_drive;
        rd_stat |=> DATA_OE;
    endproperty
    a_stat_drive: assert property (p_stat_drive)
        else $error("status read not driven");
    property p_cmd_busy;
        (st_q != ST_IDLE) |=> !DATA_OUT[0] && !DATA_OUT[1];
    endproperty
    a_cmd_busy: assert property (p_cmd_busy)
        else $error("ready bits set while busy");
    property p_rw_ready;
        (!RST && idle && !auto_on) |=> DATA_OUT[1] && DATA_OUT[0];
    endproperty
    a_rw_ready: assert property (p_rw_ready)
        else $error("ready bits clear while idle");
    property p_auto;
        (!RST && idle && AUTO_WR) |=> DATA_OUT[3] && !DATA_OUT[0];
    endproperty
    a_auto: assert property (p_auto)
        else $error("auto write ready wrong");
    property p_ctrl;
        !RST |=> DATA_OUT[5] == $past(CTRL_EN) && !DATA_OUT[4];
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("controller bit wrong");
    property p_err;
        PEEK_FAIL |-> ##2 DATA_OUT[6];
    endproperty
    a_err: assert property (p_err)
        else $error("error flag lost");
    property p_blink;
        !RST |=> DATA_OUT[7] == $past(BLINK_ON);
    endproperty
    a_blink: assert property (p_blink)
        else $error("blink bit wrong");
    property p_hold;
        (st_q == ST_HOLD && LINE_END) |=> st_q == ST_HOLD;
    endproperty
    a_hold: assert property (p_hold)
        else $error("held command left early");
    property p_exec;
        (cmd_take && !hold_cmd) |-> ##[1:8] apply;
    endproperty
    a_exec: assert property (p_exec)
        else $error("command not executed");
    property p_last;
        prm_take |=> prm_q.newest == $past(DATA_IN);
    endproperty
    a_last: assert property (p_last)
        else $error("latest parameter lost");
    property p_cursor;
        is_cur |=> CURSOR.column == $past(prm_q.older[6:0]);
    endproperty
    a_cursor: assert property (p_cursor)
        else $error("cursor column wrong");
    property p_cur_stable;
        !is_cur |=> $stable(CURSOR);
    endproperty
    a_cur_stable: assert property (p_cur_stable)
        else $error("cursor moved without command");
    property p_ptr;
        is_ptr |=> PTR_LOAD && ADDR_PTR[15:8] == $past(prm_q.newest);
    endproperty
    a_ptr: assert property (p_ptr)
        else $error("pointer high byte wrong");

endmodule : lcdhcp_port
`default_nettype wire

// >>> testbench/lcdhcp_host_model.sv
`default_nettype none
module lcdhcp_host_model (
    // Clock.
    input  wire logic       MCLK,
    // Device answer on the bus.
    input  wire logic [7:0] DATA_OUT,
    input  wire logic       DATA_OE,
    // Host strobes and write data.
    output var  logic       CE_N,
    output var  logic       RD_N,
    output var  logic       WR_N,
    output var  logic       CD,
    output var  logic [7:0] DATA_IN
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------
    // Bus idle state
    // ---------------------------------------------
    // Strobes idle high; released data shows junk, never the last byte.
    initial begin
        CE_N = 1'b1;
        RD_N = 1'b1;
        WR_N = 1'b1;
        CD = 1'b1;
        DATA_IN = 8'hA5;
    end

    // ---------------------------------------------
    // Bus cycles
    // ---------------------------------------------
    // status read cycle
    // The read is held until the device drives the bus.
    task automatic read_status(output logic [7:0] st);
        int n;
        @(posedge MCLK);
        CE_N <= 1'b0;
        RD_N <= 1'b0;
        CD <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (DATA_OE !== 1'b1 && n < 8);
        st = DATA_OUT;
        CE_N <= 1'b1;
        RD_N <= 1'b1;
    endtask : read_status

    // poll not delay
    // A fixed wait would miss the line-end hold, so the host polls.
    task automatic wait_ready(input logic [7:0] mask);
        logic [7:0] st;
        int         n;
        n = 0;
        do begin
            read_status(st);
            n++;
        end while ((st & mask) !== mask && n < 60);
    endtask : wait_ready

    // select marks byte
    // Poll may be skipped only where a test means to break the order.
    task automatic write_byte(input logic c, input logic [7:0] v,
                              input logic poll);
        if (poll) begin
            wait_ready(8'h03);
        end
        @(posedge MCLK);
        CE_N <= 1'b0;
        WR_N <= 1'b0;
        CD <= c;
        DATA_IN <= v;
        @(posedge MCLK);
        CE_N <= 1'b1;
        WR_N <= 1'b1;
        DATA_IN <= ~v;
    endtask : write_byte

    task automatic command(input logic [7:0] code, input logic [7:0] d1,
                           input logic [7:0] d2);
        write_byte(1'b0, d1, 1'b1);
        write_byte(1'b0, d2, 1'b1);
        write_byte(1'b1, code, 1'b1);
    endtask : command
endmodule : lcdhcp_host_model
`default_nettype wire

// >>> testbench/lcdhcp_port_tb.sv
`include "lcdhcp_params.svh"
`default_nettype none
module lcdhcp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcdhcp_pkg::*;

    // ---------------------------------------------
    // Signals and bookkeeping
    // ---------------------------------------------
    logic mclk, rst, line_end, auto_rd, auto_wr, ctrl_en, blink_on;
    logic peek_fail, peek_start, ce_n, rd_n, wr_n, cd, data_oe;
    logic ptr_load, cmd_other;
    logic [7:0] char_code, data_in, data_out, cmd_code;
    logic [2:0] line_cnt;
    logic [4:0] cg_offset;
    logic [15:0] addr_ptr, cg_addr;
    lcdhcp_cursor_s cursor;
    logic [31:0] seed = 32'h1AC4;
    int n_errors = 0, cmp_count = 0, cyc = 0, n_ptr = 0, n_other = 0;

    lcdhcp_port i_lcdhcp_port (.MCLK(mclk), .RST(rst), .CE_N(ce_n),
        .RD_N(rd_n), .WR_N(wr_n), .CD(cd), .DATA_IN(data_in),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .LINE_END(line_end),
        .AUTO_RD(auto_rd), .AUTO_WR(auto_wr), .CTRL_EN(ctrl_en),
        .BLINK_ON(blink_on), .PEEK_FAIL(peek_fail),
        .PEEK_START(peek_start), .CHAR_CODE(char_code),
        .LINE_CNT(line_cnt), .CURSOR(cursor), .CG_OFFSET(cg_offset),
        .ADDR_PTR(addr_ptr), .PTR_LOAD(ptr_load), .CG_ADDR(cg_addr),
        .CMD_OTHER(cmd_other), .CMD_CODE(cmd_code));

    lcdhcp_host_model i_lcdhcp_host_model (.MCLK(mclk),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .CE_N(ce_n),
        .RD_N(rd_n), .WR_N(wr_n), .CD(cd), .DATA_IN(data_in));

    always #5 mclk = ~mclk;

    // Pulses are counted here so no one-cycle report is missed.
    always @(posedge mclk) begin
        cyc++;
        if (ptr_load === 1'b1) n_ptr++;
        if (cmd_other === 1'b1) n_other++;
        if (cyc == 6000) begin
            n_errors++;
            finish_test();
        end
    end

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Bit 4 carries no meaning and is masked by the caller.
    function automatic logic [7:0] exp_status(input logic ard, awr, ctl,
                                              blk, err);
        logic man;
        man = ~(ard | awr);
        return {blk, err, ctl, 1'b0, awr, ard, man, man};
    endfunction : exp_status

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] st, d0, d1, d2, code;
        logic [11:0] et;
        logic [15:0] cur, ptr;
        logic [4:0] off;
        int np, no;
        {mclk, line_end, auto_rd, auto_wr, peek_fail, peek_start} = '0;
        {char_code, line_cnt} = '0;
        ctrl_en = 1'b1;
        blink_on = 1'b1;
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("cursor", 16'(cursor), 16'h0000);
        // Status word under random conditions; first pass all off.
        for (int i = 0; i < 12; i++) begin
            r = (i == 0) ? 32'h0 : rnd();
            {blink_on, ctrl_en, auto_wr, auto_rd} <= r[3:0];
            repeat (2) @(posedge mclk);
            i_lcdhcp_host_model.read_status(st);
            // Bit 4 carries no meaning and is left out of the compare.
            d0 = exp_status(r[0], r[1], r[2], r[3], 1'b0);
            check("drive", 16'(data_oe), 16'h0001);
            check("ready", 16'(st[1:0]), 16'(d0[1:0]));
            check("auto", 16'(st[3:2]), 16'(d0[3:2]));
            check("upper", 16'(st[7:5]), 16'(d0[7:5]));
        end
        {auto_rd, auto_wr, ctrl_en} <= 3'b001;
        $display("test status done");
        // Error flag: set, clear, set winning over clear, then clear again.
        et = 12'b101_010_111_010;
        for (int i = 0; i < 4; i++) begin
            {peek_fail, peek_start} <= et[11 - 3 * i -: 2];
            @(posedge mclk);
            {peek_fail, peek_start} <= 2'b00;
            i_lcdhcp_host_model.read_status(st);
            check("error flag", 16'(st[6]), 16'(et[9 - 3 * i]));
        end
        $display("test error flag done");
        // Register commands; early ones use all-ones bytes for masking.
        cur = '0;
        off = '0;
        ptr = '0;
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            code = (i % 4 == 0) ? `LCDHCP_CMD_CURSOR
                 : (i % 4 == 1) ? `LCDHCP_CMD_OFFSET
                 : (i % 4 == 2) ? `LCDHCP_CMD_POINTER : 8'hC0;
            {d0, d2, d1} = (i < 4) ? 24'hFFFFFF : r[23:0];
            r = rnd();
            char_code <= r[7:0];
            line_cnt <= r[10:8];
            // Extra leading byte must be pushed out by the later two.
            i_lcdhcp_host_model.write_byte(1'b0, d0, 1'b1);
            np = n_ptr;
            no = n_other;
            i_lcdhcp_host_model.command(code, d1, d2);
            i_lcdhcp_host_model.read_status(st);
            check("busy", 16'(st[1:0]), 16'h0000);
            i_lcdhcp_host_model.wait_ready(8'h03);
            case (code)
                `LCDHCP_CMD_CURSOR: cur = {4'h0, d2[4:0], d1[6:0]};
                `LCDHCP_CMD_OFFSET: off = d1[4:0];
                `LCDHCP_CMD_POINTER: ptr = {d2, d1};
                default: ;
            endcase
            check("cursor", 16'(cursor), cur);
            check("offset", 16'(cg_offset), 16'(off));
            check("pointer", addr_ptr, ptr);
            check("loads", 16'(n_ptr - np), 16'(code == 8'h24));
            check("others", 16'(n_other - no), 16'(code == 8'hC0));
            check("code", 16'(cmd_code), 16'(code));
            check("gen addr", cg_addr, {off, char_code, line_cnt});
        end
        $display("test commands done");
        // Pointer command held by line end; a new parameter byte is still taken, a new command is dropped.
        line_end <= 1'b1;
        r = rnd();
        i_lcdhcp_host_model.command(`LCDHCP_CMD_POINTER, r[7:0], r[15:8]);
        i_lcdhcp_host_model.read_status(st);
        check("held busy", 16'(st[1:0]), 16'h0000);
        i_lcdhcp_host_model.write_byte(1'b0, r[23:16], 1'b0);
        i_lcdhcp_host_model.write_byte(1'b1, `LCDHCP_CMD_CURSOR, 1'b0);
        repeat (4) @(posedge mclk);
        check("held pointer", addr_ptr, ptr);
        line_end <= 1'b0;
        i_lcdhcp_host_model.wait_ready(8'h03);
        check("pointer", addr_ptr, r[23:8]);
        check("cursor", 16'(cursor), cur);
        check("code", 16'(cmd_code), 16'(`LCDHCP_CMD_POINTER));
        $display("test line end hold done");
        finish_test();
    end
endmodule : lcdhcp_port_tb
`default_nettype wire
